/* design/nim_defs.svh */
`ifndef NIM_DEFS_SVH
`define NIM_DEFS_SVH
// Register regions, selected by address bits 11:8
`define NIM_REGION_CMB 4'h0
`define NIM_REGION_IND 4'h1
`define NIM_REGION_MISC 4'h2
// Combined controller words, offset within its 64-byte slot
`define NIM_CMB_EVT_LO 6'h00
`define NIM_CMB_EVT_HI 6'h04
`define NIM_CMB_MASK_LO 6'h08
`define NIM_CMB_MASK_HI 6'h0c
`define NIM_CMB_PEND_LO 6'h10
`define NIM_CMB_PEND_HI 6'h14
`define NIM_CMB_ACK_LO 6'h18
`define NIM_CMB_ACK_HI 6'h1c
`define NIM_CMB_EOI 6'h20
`define NIM_CMB_WAIT 6'h24
// Individual selector: word index 0..13 per output, 14 is the pulse length
`define NIM_IND_COUNT 14
`define NIM_IND_LEN_IDX 4'he
// Miscellaneous words
`define NIM_MISC_EXT_CFG 8'h00
`define NIM_MISC_SW_EVT 8'h04
// Field positions
`define NIM_SEL_LSB 0
`define NIM_HOLD_LSB 16
`define NIM_EXT_LSB 56
`define NIM_SW_LSB 60
// Reset values
`define NIM_MASK_RST 64'hffffffffffffffff
`define NIM_WAIT_RST 16'h0000
`define NIM_HOLD_RST 12'h000
`define NIM_LEN_RST 8'h00
`define NIM_EXT_CFG_RST 12'h000
// Timing
`define NIM_CLK_MHZ 125
`define NIM_SW_PULSE_NS 8
`define NIM_SW_PULSE_CYC ((`NIM_SW_PULSE_NS * `NIM_CLK_MHZ) / 1000)
`endif

/* design/nim_pkg.sv */
package nim_pkg;
  typedef struct packed {
    logic [11:0] hold;
    logic [5:0] sel;
  } nim_ind_cfg_type;
  typedef struct packed {
    logic [3:0] rise;
    logic [3:0] edge_en;
    logic [3:0] low;
  } nim_ext_cfg_type;
  typedef struct packed {
    logic evt_lo;
    logic evt_hi;
    logic mask_lo;
    logic mask_hi;
    logic ack_lo;
    logic ack_hi;
    logic eoi;
    logic wait_w;
  } nim_cmb_wr_type;
  function automatic logic [63:0] nim_word64(input logic [31:0] d, input logic lo, input logic hi);
    nim_word64 = {(hi ? d : 32'h0), (lo ? d : 32'h0)};
  endfunction : nim_word64
endpackage : nim_pkg

/* design/nim_combined_irq_controller.sv */
`timescale 1ns/10ps
`default_nettype none
`include "nim_defs.svh"
module nim_combined_irq_controller import nim_pkg::*; #(
  parameter int WAIT_W = 16
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [63:0] events,
  input wire nim_cmb_wr_type wr,
  input wire logic [31:0] wdata,
  output logic [63:0] event_q,
  output logic [63:0] mask_q,
  output logic [WAIT_W-1:0] wait_q,
  output logic irq
);
  logic [63:0] event_reg, event_next, mask_reg, mask_next, pend;
  logic [WAIT_W-1:0] wait_reg, wait_next, rearm_reg, rearm_next;
  logic irq_reg, irq_next;
  always_comb begin
    // Set beats acknowledge in the same cycle
    event_next = (event_reg & ~nim_word64(wdata, wr.ack_lo, wr.ack_hi))
      | events | nim_word64(wdata, wr.evt_lo, wr.evt_hi);
    mask_next = mask_reg;
    if (wr.mask_lo) begin
      mask_next[31:0] = wdata;
    end
    if (wr.mask_hi) begin
      mask_next[63:32] = wdata;
    end
    wait_next = wr.wait_w ? wdata[WAIT_W-1:0] : wait_reg;
    pend = event_reg & ~mask_reg;
    rearm_next = (rearm_reg != '0) ? rearm_reg - WAIT_W'(1) : rearm_reg;
    irq_next = irq_reg;
    if (wr.eoi) begin
      irq_next = 1'b0;
      rearm_next = wait_reg;
    end else if (rearm_reg == '0 && pend != 64'h0) begin
      irq_next = 1'b1;
    end
  end
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      event_reg <= 64'h0;
      mask_reg <= `NIM_MASK_RST;
      wait_reg <= WAIT_W'(`NIM_WAIT_RST);
      rearm_reg <= '0;
      irq_reg <= 1'b0;
    end else begin
      event_reg <= event_next;
      mask_reg <= mask_next;
      wait_reg <= wait_next;
      rearm_reg <= rearm_next;
      irq_reg <= irq_next;
    end
  end
  assign event_q = event_reg;
  assign mask_q = mask_reg;
  assign wait_q = wait_reg;
  assign irq = irq_reg;
endmodule : nim_combined_irq_controller
`default_nettype wire

/* design/nim_individual_irq_selector.sv */
`timescale 1ns/10ps
`default_nettype none
`include "nim_defs.svh"
module nim_individual_irq_selector import nim_pkg::*; #(
  parameter int LEN_W = 8
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [63:0] events,
  input wire logic wr,
  input wire nim_ind_cfg_type wdata,
  input wire logic [LEN_W-1:0] len,
  output nim_ind_cfg_type cfg,
  output logic irq
);
  logic [5:0] sel_reg, sel_next;
  logic [11:0] timer_reg, timer_next;
  logic [LEN_W-1:0] stretch_reg, stretch_next;
  logic pend_reg, pend_next, irq_reg, irq_next, raw, fire;
  always_comb begin
    raw = events[sel_reg];
    // Idle timer passes the event straight on, pending one included
    fire = (timer_reg == 12'h000) && (raw || pend_reg);
    pend_next = (timer_reg != 12'h000) ? (pend_reg | raw) : 1'b0;
    timer_next = (timer_reg != 12'h000) ? timer_reg - 12'h001 : timer_reg;
    sel_next = sel_reg;
    if (wr) begin
      sel_next = wdata.sel;
      timer_next = wdata.hold;
    end
    stretch_next = fire ? len : ((stretch_reg != '0) ? stretch_reg - LEN_W'(1) : stretch_reg);
    irq_next = fire || (stretch_reg != '0);
  end
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      sel_reg <= 6'h00;
      timer_reg <= `NIM_HOLD_RST;
      stretch_reg <= '0;
      pend_reg <= 1'b0;
      irq_reg <= 1'b0;
    end else begin
      sel_reg <= sel_next;
      timer_reg <= timer_next;
      stretch_reg <= stretch_next;
      pend_reg <= pend_next;
      irq_reg <= irq_next;
    end
  end
  assign cfg = '{hold: timer_reg, sel: sel_reg};
  assign irq = irq_reg;
endmodule : nim_individual_irq_selector
`default_nettype wire

/* design/nim_network_irq_manager.sv */
`timescale 1ns/10ps
`default_nettype none
`include "nim_defs.svh"
module nim_network_irq_manager import nim_pkg::*; #(
  parameter int WAIT_W = 16,
  parameter int LEN_W = 8
) (
  input wire logic SYS_CLK,
  input wire logic RESETN,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [11:0] PADDR,
  input wire logic [31:0] PWDATA,
  output logic [31:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  input wire logic [55:0] ENGINE_EVENT,
  input wire logic [3:0] EXTERNAL_EVENT,
  output logic [15:0] PROCESSOR_IRQ_OUTPUTS,
  output logic [15:0] HOST_IRQ_OUTPUTS
);
  localparam logic [3:0] SW_PULSE_CYC = 4'(`NIM_SW_PULSE_CYC > 0 ? `NIM_SW_PULSE_CYC : 1);

  // Reset release
  logic rst_s1_reg, rst_n;
  always_ff @(posedge SYS_CLK or negedge RESETN) begin
    if (!RESETN) begin
      rst_s1_reg <= 1'b0;
      rst_n <= 1'b0;
    end else begin
      rst_s1_reg <= 1'b1;
      rst_n <= rst_s1_reg;
    end
  end

  // Bus slave: one wait state, answer registered
  logic pready_reg, pready_next, pslverr_reg, pslverr_next;
  logic [31:0] prdata_reg, prdata_next, rd_data;
  logic rd_hit, access, wr_go;
  logic [3:0] region;
  logic [1:0] cmb_idx;
  logic ind_sub;
  logic [3:0] ind_idx;

  // Event sources
  logic [3:0] ext_s1_reg, ext_s2_reg, ext_prev_reg, ext_evt;
  nim_ext_cfg_type ext_cfg_reg, ext_cfg_next;
  logic [3:0] sw_bits_reg, sw_bits_next, sw_cnt_reg, sw_cnt_next;
  logic [63:0] events;

  // Per-controller and per-output signals
  nim_cmb_wr_type cmb_wr [4];
  logic [63:0] cmb_event [4];
  logic [63:0] cmb_mask [4];
  logic [WAIT_W-1:0] cmb_wait [4];
  logic [3:0] cmb_irq;
  logic ind_wr [2][`NIM_IND_COUNT];
  nim_ind_cfg_type ind_cfg [2][`NIM_IND_COUNT];
  logic [`NIM_IND_COUNT-1:0] ind_irq [2];
  logic [LEN_W-1:0] len_reg [2];
  logic [LEN_W-1:0] len_next [2];

  assign region = PADDR[11:8];
  assign cmb_idx = PADDR[7:6];
  assign ind_sub = PADDR[6];
  assign ind_idx = PADDR[5:2];
  assign access = PSEL && PENABLE && !pready_reg;
  assign wr_go = PSEL && PENABLE && pready_reg && PWRITE && !pslverr_reg;

  // External pins: synchroniser first, then polarity and edge logic on the second stage
  always_ff @(posedge SYS_CLK or negedge rst_n) begin
    if (!rst_n) begin
      ext_s1_reg <= 4'h0;
      ext_s2_reg <= 4'h0;
      ext_prev_reg <= 4'h0;
    end else begin
      ext_s1_reg <= EXTERNAL_EVENT;
      ext_s2_reg <= ext_s1_reg;
      ext_prev_reg <= ext_s2_reg;
    end
  end

  always_comb begin
    for (int i = 0; i < 4; i++) begin
      if (ext_cfg_reg.edge_en[i]) begin
        ext_evt[i] = ext_cfg_reg.rise[i] ? (ext_s2_reg[i] && !ext_prev_reg[i])
          : (!ext_s2_reg[i] && ext_prev_reg[i]);
      end else begin
        ext_evt[i] = ext_s2_reg[i] ^ ext_cfg_reg.low[i];
      end
    end
  end

  // One vector feeds every controller and selector alike
  assign events = {sw_bits_reg, ext_evt, ENGINE_EVENT};

  // Address decode and read mux
  always_comb begin
    rd_data = 32'h0;
    rd_hit = 1'b0;
    if (PADDR[1:0] == 2'b00) begin
      case (region)
        `NIM_REGION_CMB: begin
          rd_hit = 1'b1;
          case (PADDR[5:0])
            `NIM_CMB_EVT_LO: rd_data = cmb_event[cmb_idx][31:0];
            `NIM_CMB_EVT_HI: rd_data = cmb_event[cmb_idx][63:32];
            `NIM_CMB_MASK_LO: rd_data = cmb_mask[cmb_idx][31:0];
            `NIM_CMB_MASK_HI: rd_data = cmb_mask[cmb_idx][63:32];
            `NIM_CMB_PEND_LO: rd_data = cmb_event[cmb_idx][31:0] & ~cmb_mask[cmb_idx][31:0];
            `NIM_CMB_PEND_HI: rd_data = cmb_event[cmb_idx][63:32] & ~cmb_mask[cmb_idx][63:32];
            `NIM_CMB_ACK_LO,
            `NIM_CMB_ACK_HI,
            `NIM_CMB_EOI: rd_data = 32'h0;
            `NIM_CMB_WAIT: rd_data = 32'(cmb_wait[cmb_idx]);
            default: rd_hit = 1'b0;
          endcase
        end
        `NIM_REGION_IND: begin
          if (PADDR[7]) begin
            rd_hit = 1'b0;
          end else if (ind_idx == `NIM_IND_LEN_IDX) begin
            rd_hit = 1'b1;
            rd_data = 32'(len_reg[ind_sub]);
          end else if (ind_idx < 4'(`NIM_IND_COUNT)) begin
            rd_hit = 1'b1;
            rd_data[`NIM_SEL_LSB +: 6] = ind_cfg[ind_sub][ind_idx].sel;
            rd_data[`NIM_HOLD_LSB +: 12] = ind_cfg[ind_sub][ind_idx].hold;
          end
        end
        `NIM_REGION_MISC: begin
          case (PADDR[7:0])
            `NIM_MISC_EXT_CFG: begin
              rd_hit = 1'b1;
              rd_data = 32'(ext_cfg_reg);
            end
            `NIM_MISC_SW_EVT: begin
              rd_hit = 1'b1;
              rd_data = 32'h0;
            end
            default: rd_hit = 1'b0;
          endcase
        end
        default: rd_hit = 1'b0;
      endcase
    end
  end

  always_comb begin
    pready_next = access;
    pslverr_next = access && !rd_hit;
    prdata_next = prdata_reg;
    if (access) begin
      prdata_next = PWRITE ? 32'h0 : rd_data;
    end
  end

  always_ff @(posedge SYS_CLK or negedge rst_n) begin
    if (!rst_n) begin
      pready_reg <= 1'b0;
      pslverr_reg <= 1'b0;
      prdata_reg <= 32'h0;
    end else begin
      pready_reg <= pready_next;
      pslverr_reg <= pslverr_next;
      prdata_reg <= prdata_next;
    end
  end

  // Write strobes; pending words have no strobe, so writes there fall away
  always_comb begin
    for (int c = 0; c < 4; c++) begin
      cmb_wr[c] = '0;
      if (wr_go && region == `NIM_REGION_CMB && cmb_idx == 2'(c)) begin
        cmb_wr[c].evt_lo = (PADDR[5:0] == `NIM_CMB_EVT_LO);
        cmb_wr[c].evt_hi = (PADDR[5:0] == `NIM_CMB_EVT_HI);
        cmb_wr[c].mask_lo = (PADDR[5:0] == `NIM_CMB_MASK_LO);
        cmb_wr[c].mask_hi = (PADDR[5:0] == `NIM_CMB_MASK_HI);
        cmb_wr[c].ack_lo = (PADDR[5:0] == `NIM_CMB_ACK_LO);
        cmb_wr[c].ack_hi = (PADDR[5:0] == `NIM_CMB_ACK_HI);
        cmb_wr[c].eoi = (PADDR[5:0] == `NIM_CMB_EOI);
        cmb_wr[c].wait_w = (PADDR[5:0] == `NIM_CMB_WAIT);
      end
    end
    for (int s = 0; s < 2; s++) begin
      for (int j = 0; j < `NIM_IND_COUNT; j++) begin
        ind_wr[s][j] = wr_go && region == `NIM_REGION_IND && !PADDR[7]
          && ind_sub == 1'(s) && ind_idx == 4'(j);
      end
    end
  end

  // Configuration words and the software pulse
  always_comb begin
    ext_cfg_next = ext_cfg_reg;
    if (wr_go && region == `NIM_REGION_MISC && PADDR[7:0] == `NIM_MISC_EXT_CFG) begin
      ext_cfg_next = PWDATA[11:0];
    end
    for (int s = 0; s < 2; s++) begin
      len_next[s] = len_reg[s];
      if (wr_go && region == `NIM_REGION_IND && !PADDR[7] && ind_sub == 1'(s)
          && ind_idx == `NIM_IND_LEN_IDX) begin
        len_next[s] = PWDATA[LEN_W-1:0];
      end
    end
    // The written value only launches the pulse; nothing is kept for readback
    sw_bits_next = sw_bits_reg;
    sw_cnt_next = sw_cnt_reg;
    if (wr_go && region == `NIM_REGION_MISC && PADDR[7:0] == `NIM_MISC_SW_EVT) begin
      sw_bits_next = PWDATA[3:0];
      sw_cnt_next = SW_PULSE_CYC - 4'h1;
    end else if (sw_cnt_reg != 4'h0) begin
      sw_cnt_next = sw_cnt_reg - 4'h1;
    end else begin
      sw_bits_next = 4'h0;
    end
  end

  always_ff @(posedge SYS_CLK or negedge rst_n) begin
    if (!rst_n) begin
      ext_cfg_reg <= `NIM_EXT_CFG_RST;
      len_reg[0] <= LEN_W'(`NIM_LEN_RST);
      len_reg[1] <= LEN_W'(`NIM_LEN_RST);
      sw_bits_reg <= 4'h0;
      sw_cnt_reg <= 4'h0;
    end else begin
      ext_cfg_reg <= ext_cfg_next;
      len_reg[0] <= len_next[0];
      len_reg[1] <= len_next[1];
      sw_bits_reg <= sw_bits_next;
      sw_cnt_reg <= sw_cnt_next;
    end
  end

  // Controllers 0,1 serve the processor, 2,3 the host
  for (genvar c = 0; c < 4; c++) begin : g_cmb
    nim_combined_irq_controller #(
      .WAIT_W(WAIT_W)
    ) u_cmb (
      .clk(SYS_CLK),
      .rst_n(rst_n),
      .events(events),
      .wr(cmb_wr[c]),
      .wdata(PWDATA),
      .event_q(cmb_event[c]),
      .mask_q(cmb_mask[c]),
      .wait_q(cmb_wait[c]),
      .irq(cmb_irq[c])
    );
  end

  for (genvar s = 0; s < 2; s++) begin : g_sub
    for (genvar j = 0; j < `NIM_IND_COUNT; j++) begin : g_ind
      nim_individual_irq_selector #(
        .LEN_W(LEN_W)
      ) u_ind (
        .clk(SYS_CLK),
        .rst_n(rst_n),
        .events(events),
        .wr(ind_wr[s][j]),
        .wdata(nim_ind_cfg_type'({PWDATA[`NIM_HOLD_LSB +: 12], PWDATA[`NIM_SEL_LSB +: 6]})),
        .len(len_reg[s]),
        .cfg(ind_cfg[s][j]),
        .irq(ind_irq[s][j])
      );
    end
  end

  // Every interrupt bit leaves from a flip-flop inside its controller or selector
  assign PROCESSOR_IRQ_OUTPUTS = {ind_irq[0], cmb_irq[1:0]};
  assign HOST_IRQ_OUTPUTS = {ind_irq[1], cmb_irq[3:2]};
  assign PRDATA = prdata_reg;
  assign PREADY = pready_reg;
  assign PSLVERR = pslverr_reg;
endmodule : nim_network_irq_manager
`default_nettype wire

/* bench/nim_network_irq_manager_sva.sv */
`timescale 1ns/10ps
`default_nettype none
module nim_network_irq_manager_sva #(
  parameter int WAIT_W = 16,
  parameter int LEN_W = 8
) (
  input wire logic SYS_CLK,
  input wire logic RESETN,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [11:0] PADDR,
  input wire logic [31:0] PWDATA,
  input wire logic [31:0] PRDATA,
  input wire logic PREADY,
  input wire logic PSLVERR,
  input wire logic [55:0] ENGINE_EVENT,
  input wire logic [3:0] EXTERNAL_EVENT,
  input wire logic [15:0] PROCESSOR_IRQ_OUTPUTS,
  input wire logic [15:0] HOST_IRQ_OUTPUTS
);
  logic [3:0] cmb;
  assign cmb = {HOST_IRQ_OUTPUTS[1:0], PROCESSOR_IRQ_OUTPUTS[1:0]};
  default clocking @(posedge SYS_CLK); endclocking
  default disable iff (!RESETN);
  pready_wait_a: assert property (PSEL && PENABLE && !PREADY |=> PREADY)
    else $error("Ready missing after one wait state");
  pready_pulse_a: assert property (PREADY |=> !PREADY)
    else $error("Ready longer than one cycle");
  pready_phase_a: assert property (PREADY |-> PSEL && PENABLE && $past(PENABLE))
    else $error("Ready outside access phase");
  slverr_align_a: assert property (PREADY && PADDR[1:0] != 2'h0 |-> PSLVERR)
    else $error("Misaligned access not refused");
  swevt_zero_a: assert property (PREADY && !PWRITE && PADDR == 12'h204 |-> PRDATA == 32'h0)
    else $error("Software event word read nonzero");
  ack_zero_a: assert property (PREADY && !PWRITE && PADDR[11:8] == 4'h0 && PADDR[5:3] == 3'h3 |-> PRDATA == 32'h0)
    else $error("Acknowledge word read nonzero");
  eoi_drop_a: assert property (PREADY && PWRITE && PADDR[11:8] == 4'h0 && PADDR[5:0] == 6'h20
    |=> !cmb[$past(PADDR[7:6])]) else $error("Combined irq stayed up after end of interrupt");
  reset_quiet_a: assert property ($rose(RESETN) |-> PROCESSOR_IRQ_OUTPUTS == 16'h0 && HOST_IRQ_OUTPUTS == 16'h0)
    else $error("Irq output high at reset release");
endmodule : nim_network_irq_manager_sva
`default_nettype wire

/* bench/nim_irq_sink.sv */
`timescale 1ns/10ps
`default_nettype none
module nim_irq_sink (
  input wire logic clk,
  input wire logic [31:0] irq,
  output int unsigned rises [32],
  output int unsigned width [32]
);
  // Behaves as a level-sampling receiver; it counts edges and pulse lengths
  logic [31:0] prev = 32'h0;
  int unsigned run [32];
  always @(posedge clk) begin
    for (int i = 0; i < 32; i++) begin
      if (irq[i] === 1'b1) begin
        if (prev[i] !== 1'b1) rises[i] <= rises[i] + 1;
        run[i] = run[i] + 1;
      end else if (run[i] != 0) begin
        width[i] <= run[i];
        run[i] = 0;
      end
    end
    prev <= irq;
  end
endmodule : nim_irq_sink
`default_nettype wire

/* bench/nim_network_irq_manager_tb_top.sv */
`timescale 1ns/10ps
`default_nettype none
module nim_network_irq_manager_tb_top;
  logic sys_clk = 1'b0, resetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, pready, pslverr, err;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, r, all_irq;
  logic [55:0] engine_event = 56'h0;
  logic [3:0] external_event = 4'h0;
  logic [15:0] proc_irq, host_irq;
  int unsigned rises [32], width [32];
  int miscompares = 0, n_compared = 0;
  assign all_irq = {host_irq, proc_irq};
  always #4 sys_clk = ~sys_clk;
  nim_network_irq_manager #(.WAIT_W(16), .LEN_W(8)) nim_network_irq_manager_i (.SYS_CLK(sys_clk),
    .RESETN(resetn), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata),
    .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr), .ENGINE_EVENT(engine_event),
    .EXTERNAL_EVENT(external_event), .PROCESSOR_IRQ_OUTPUTS(proc_irq), .HOST_IRQ_OUTPUTS(host_irq));
  nim_irq_sink nim_irq_sink_i (.clk(sys_clk), .irq(all_irq), .rises(rises), .width(width));
  task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_compared++;
    if (g !== e) begin
      miscompares++;
      $display("BAD %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  task cyc(input int n);
    repeat (n) @(posedge sys_clk);
  endtask : cyc
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge sys_clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge sys_clk);
    penable <= 1'b1;
    do begin
      @(posedge sys_clk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    chk("pready", 1, pready);
    r = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task wr(input logic [11:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask : wr
  task rd(input logic [11:0] a);
    apb(1'b0, a, 32'h0);
  endtask : rd
  task evt(input int b);
    @(posedge sys_clk);
    engine_event <= 56'h1 << b;
    @(posedge sys_clk);
    engine_event <= 56'h0;
  endtask : evt
  task ext(input logic [3:0] v);
    @(posedge sys_clk);
    external_event <= v;
    cyc(6);
  endtask : ext
  // Bounded so a stuck output ends as a count instead of a hang
  task until_high(input int b, output int n);
    n = 0;
    do begin
      @(posedge sys_clk);
      n++;
    end while (all_irq[b] !== 1'b1 && n < 60);
  endtask : until_high
  task finish_test;
    $display("Compared %0d, mismatches %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : finish_test
  initial begin
    int n;
    cyc(3);
    resetn <= 1'b1;
    cyc(3);
    rd(12'h008); chk("mask_rst", 32'hffffffff, r);
    rd(12'h0e4); chk("wait_rst", 32'h0, r);
    rd(12'h100); chk("ind_rst", 32'h0, r);
    rd(12'h200); chk("ext_rst", 32'h0, r);
    rd(12'h300); chk("unmapped", 1, err);
    wr(12'h002, 32'h1); chk("misaligned", 1, err);
    $display("Test reset done");
    wr(12'h000, 32'h5); wr(12'h000, 32'h2); rd(12'h000); chk("evt_or", 32'h7, r);
    wr(12'h010, 32'hffffffff); rd(12'h010); chk("pend_masked", 32'h0, r);
    wr(12'h008, 32'hfffffffe); rd(12'h010); chk("pend", 32'h1, r);
    chk("irq_on", 1, all_irq[0]); chk("irq_masked", 0, all_irq[1]);
    wr(12'h018, r); rd(12'h000); chk("evt_ack", 32'h6, r);
    wr(12'h020, 32'h0); cyc(1); chk("eoi", 0, all_irq[0]);
    wr(12'h018, 32'h6);
    $display("Test event register done");
    wr(12'h024, 32'ha); wr(12'h000, 32'h1); cyc(2); chk("irq_again", 1, all_irq[0]);
    wr(12'h020, 32'h0); until_high(0, n); chk("rearm", 1, n >= 10 && n <= 13);
    wr(12'h018, 32'h1); wr(12'h024, 32'h0); wr(12'h008, 32'hffffffff); wr(12'h020, 32'h0);
    evt(3);
    for (int k = 0; k < 4; k++) begin
      rd(12'(k * 64)); chk("evt_same", 32'h8, r);
      wr(12'(k * 64 + 8), 32'hfffffff7); cyc(3); chk("cmb_irq", 1, all_irq[k < 2 ? k : k + 14]);
      wr(12'(k * 64 + 24), 32'h8); wr(12'(k * 64 + 8), 32'hffffffff); wr(12'(k * 64 + 32), 32'h0);
    end
    $display("Test combined done");
    wr(12'h138, 32'h3); wr(12'h100, 32'h5); evt(5); until_high(2, n); chk("ind_lat", 1, n <= 2);
    cyc(6); chk("ind_width", 4, width[2]); chk("ind_rise", 1, rises[2]);
    wr(12'h104, 32'd60); wr(12'h140, 32'd61); wr(12'h204, 32'hf);
    rd(12'h204); chk("sw_read", 32'h0, r);
    rd(12'h084); chk("sw_evt", 32'hf0000000, r);
    cyc(4); chk("sw_ind", 1, rises[3] == 1 && width[3] == 4);
    chk("sw_host", 1, rises[18] == 1 && width[18] == 1);
    for (int k = 0; k < 4; k++) wr(12'(k * 64 + 28), 32'hf0000000);
    $display("Test individual done");
    wr(12'h100, 32'h00280005); cyc(3); rd(12'h100); chk("hold_run", 1, r[27:16] < 40 && r[27:16] > 30);
    evt(5); cyc(2); chk("held", 1, rises[2]);
    wr(12'h100, 32'h00060005); until_high(2, n); chk("reload", 1, n >= 4 && n <= 9);
    cyc(40); chk("fire_once", 2, rises[2]);
    rd(12'h100); chk("hold_zero", 32'h5, r);
    $display("Test hold-off done");
    ext(4'h1); rd(12'h004); chk("ext_level", 1, r[24]);
    ext(4'h0); wr(12'h01c, 32'h01000000); wr(12'h200, 32'h020);
    ext(4'h2); rd(12'h004); chk("ext_rise_ign", 0, r[25]);
    ext(4'h0); rd(12'h004); chk("ext_fall", 1, r[25]);
    wr(12'h200, 32'h004); cyc(6); rd(12'h004); chk("ext_low", 1, r[26]);
    wr(12'h200, 32'h880); ext(4'h8); rd(12'h004); chk("ext_rise", 1, r[27]);
    $display("Test external done");
    finish_test;
  end
  // Whole sequence takes under 2000 cycles; ten times that means a hang
  initial begin
    cyc(20000);
    miscompares++;
    finish_test;
  end
endmodule : nim_network_irq_manager_tb_top
bind nim_network_irq_manager nim_network_irq_manager_sva #(.WAIT_W(WAIT_W), .LEN_W(LEN_W))
  nim_network_irq_manager_sva_i (.SYS_CLK(SYS_CLK), .RESETN(RESETN), .PSEL(PSEL), .PENABLE(PENABLE),
  .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR),
  .ENGINE_EVENT(ENGINE_EVENT), .EXTERNAL_EVENT(EXTERNAL_EVENT),
  .PROCESSOR_IRQ_OUTPUTS(PROCESSOR_IRQ_OUTPUTS), .HOST_IRQ_OUTPUTS(HOST_IRQ_OUTPUTS));
`default_nettype wire
